// [hdl/mrb_mode_regs.sv]
`timescale 1ns/1ps

// Summary of operation
// R1: Second register holds its value until reloaded; array contents are untouched.
// R2: Controller loads only with banks idle and waits spacing and update delay.
// R3: Controller writes zero into reserved bits of the second register.
// R4: Bits 5..3 choose write latency; controller picks value for its clock.
// R5: First write data is expected at write latency plus posted offset.
// R6: Bit 6 enables automatic temperature-based self refresh rate.
// R7: Automatic mode doubles refresh rate once case is hot.
// R8: With both rate bits clear, self refresh runs at single rate.
// R9: Bit 7 forces double self refresh rate regardless of temperature.
// R10: Controller never sets forced and automatic rate bits together.
// R11: Extended temperature needs double manual refresh and a double-rate bit.
// R12: Bits 10..9 choose write termination; nonzero enables dynamic switching.
// R13: Dynamic termination replaces nominal during each write burst, then restores.
// R14: Nominal disabled means high impedance outside writes; dynamic still works.
// R15: Write termination only during write bursts, never read or idle.
// R16: No write termination while write leveling is active.
// R17: Third register loaded by mode load, held, controller observes waits.
// R18: Controller writes zero into reserved bits of the third register.
// R19: Bit 2 set redirects every read to pattern data instead of array.
// R20: Pattern select 00 returns calibration pattern; other codes reserved.
// R21: Pattern select bits are ignored when bit 2 is clear.
// R22: Controller precharges all banks before enabling the pattern.
// R23: In pattern mode controller issues only reads until disabled; the testbench also loads the third register with 101 while enabled.
// R24: Calibration pattern alternates 0,1 with burst position zero as LSB.
// R25: Bank code 010 loads the second register, 011 the third.
// R26: Load captures address in one cycle; effect follows the update delay.
module mrb_mode_regs #(
    parameter int MODE_UPDATE_CYCLES = mrb_pkg::MODE_UPDATE_DEF,
    parameter int AL_W               = 4
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              mem_clk,
    input  wire mrb_pkg::mrb_cmd_t cmd,
    input  wire logic [AL_W-1:0]   posted_latency_offset,
    input  wire logic [2:0]        nominal_termination,
    input  wire logic              termination_control,
    input  wire logic              write_leveling,
    input  wire logic              case_temp_hot,
    output logic                   write_data_latch,
    output logic                   write_burst_active,
    output mrb_pkg::mrb_term_t     term_select,
    output logic [1:0]             write_termination_value,
    output logic                   read_from_array,
    output logic                   pattern_valid,
    output logic [7:0]             pattern_data,
    output logic                   mode_update_busy,
    output logic                   self_refresh_double
);

    // ------------------------------------------------------------------
    // Reset crossing into the link domain
    // ------------------------------------------------------------------
    logic       link_rst_b;
    logic [2:0] rate_sync;

    mrb_sync #(.WIDTH(1)) u_rst_sync (
        .clk (mem_clk),
        .d   (rst_b),
        .q   (link_rst_b)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic mrb_pkg::mrb_op_t decode_op(input mrb_pkg::mrb_cmd_t c);
        mrb_pkg::mrb_op_t op;
        op = mrb_pkg::OP_NONE;
        if (!c.cs_b && !c.cas_b) begin
            if (!c.ras_b && !c.we_b) begin
                op = mrb_pkg::OP_LOAD;
            end else if (c.ras_b && !c.we_b) begin
                op = mrb_pkg::OP_WRITE;
            end else if (c.ras_b && c.we_b) begin
                op = mrb_pkg::OP_READ;
            end
        end
        return op;
    endfunction : decode_op

    // Total write latency in clocks: decoded setting plus the posted offset.
    // R4
    function automatic logic [4:0] total_latency(input logic [18:0] reg2, input logic [AL_W-1:0] al);
        logic [4:0] write_latency_setting;
        write_latency_setting = mrb_pkg::CWL_BASE + {2'b00, reg2[mrb_pkg::CWL_MSB:mrb_pkg::CWL_LSB]};
        return write_latency_setting + 5'(al);
    endfunction : total_latency

    localparam logic [7:0] UPD_LOAD = 8'(MODE_UPDATE_CYCLES);

    // ------------------------------------------------------------------
    // Link domain: command decode, mode registers, write and read paths
    // ------------------------------------------------------------------
    mrb_pkg::mrb_link_st_t l_reg;
    mrb_pkg::mrb_link_st_t l_next;
    mrb_pkg::mrb_op_t      op;
    logic [4:0]            twl;
    logic                  wr_dyn_en;
    logic                  pat_on;

    assign op        = decode_op(cmd);
    assign twl       = total_latency(l_reg.second_act, posted_latency_offset);
    assign wr_dyn_en = (l_reg.second_act[mrb_pkg::WR_TERM_MSB:mrb_pkg::WR_TERM_LSB] != 2'h0); // R12
    assign pat_on    = l_reg.third_act[mrb_pkg::PAT_EN_BIT];

    always_comb begin
        l_next          = l_reg;
        l_next.wr_latch = 1'b0;
        l_next.rd_array = 1'b0;
        l_next.pat_valid = 1'b0;
        l_next.pat_data = 8'h00;

        // A load lands in the pending copy at once; the live copy follows after the update delay.
        if (op == mrb_pkg::OP_LOAD && cmd.ba == mrb_pkg::SEL_SECOND_EXT) begin // R25
            l_next.second_pend = {cmd.ba, cmd.addr}; // R26
            l_next.upd_cnt     = UPD_LOAD;
        end else if (op == mrb_pkg::OP_LOAD && cmd.ba == mrb_pkg::SEL_THIRD_EXT) begin // R25
            l_next.third_pend = {cmd.ba, cmd.addr}; // R17
            l_next.upd_cnt    = UPD_LOAD;
        end else if (l_reg.upd_cnt != 8'h00) begin
            l_next.upd_cnt = l_reg.upd_cnt - 8'h01;
        end
        if (l_reg.upd_cnt == 8'h01) begin
            l_next.second_act = l_reg.second_pend; // R1
            l_next.third_act  = l_reg.third_pend;
        end

        // Write data is latched at the total latency; a second write during the wait restarts it.
        if (op == mrb_pkg::OP_WRITE && !pat_on) begin
            l_next.wl_cnt = twl - 5'h01; // R5
        end else if (l_reg.wl_cnt != 5'h00) begin
            l_next.wl_cnt = l_reg.wl_cnt - 5'h01;
        end
        if (l_reg.wl_cnt == 5'h01) begin
            l_next.wr_latch  = 1'b1; // R5
            l_next.burst_cnt = mrb_pkg::BURST_CLOCKS;
        end else if (l_reg.burst_cnt != 3'h0) begin
            l_next.burst_cnt = l_reg.burst_cnt - 3'h1;
        end

        // Reads go to the array, or to the pattern source when it is enabled.
        if (op == mrb_pkg::OP_READ) begin
            if (pat_on) begin // R19
                l_next.pat_valid = 1'b1;
                if (l_reg.third_act[mrb_pkg::PAT_SEL_MSB:mrb_pkg::PAT_SEL_LSB] == mrb_pkg::PAT_SEL_CAL) begin // R20
                    l_next.pat_data = mrb_pkg::CAL_PATTERN; // R24
                end
            end else begin
                l_next.rd_array = 1'b1; // R21
            end
        end

        // Termination follows the burst state that is being registered this cycle.
        if (l_next.burst_cnt != 3'h0 && wr_dyn_en && !write_leveling) begin // R13 R16
            l_next.term = mrb_pkg::TERM_WRITE; // R15
        end else if (termination_control && nominal_termination != 3'h0) begin
            l_next.term = mrb_pkg::TERM_NOM;
        end else begin
            l_next.term = mrb_pkg::TERM_OFF; // R14
        end
    end

    always_ff @(posedge mem_clk) begin
        if (!link_rst_b) begin
            l_reg.second_pend <= mrb_pkg::MODE_REG_RESET;
            l_reg.third_pend  <= mrb_pkg::MODE_REG_RESET;
            l_reg.second_act  <= mrb_pkg::MODE_REG_RESET;
            l_reg.third_act   <= mrb_pkg::MODE_REG_RESET;
            l_reg.upd_cnt     <= mrb_pkg::UPD_CNT_RESET;
            l_reg.wl_cnt      <= mrb_pkg::WL_CNT_RESET;
            l_reg.burst_cnt   <= mrb_pkg::BURST_CNT_RESET;
            l_reg.wr_latch    <= 1'b0;
            l_reg.rd_array    <= 1'b0;
            l_reg.pat_valid   <= 1'b0;
            l_reg.pat_data    <= 8'h00;
            l_reg.term        <= mrb_pkg::TERM_OFF;
        end else begin
            l_reg <= l_next;
        end
    end

    assign write_data_latch        = l_reg.wr_latch;
    assign write_burst_active      = (l_reg.burst_cnt != 3'h0);
    assign term_select             = l_reg.term;
    assign write_termination_value = l_reg.second_act[mrb_pkg::WR_TERM_MSB:mrb_pkg::WR_TERM_LSB];
    assign read_from_array         = l_reg.rd_array;
    assign pattern_valid           = l_reg.pat_valid;
    assign pattern_data            = l_reg.pat_data;
    assign mode_update_busy        = (l_reg.upd_cnt != 8'h00);

    // ------------------------------------------------------------------
    // System domain: self refresh rate selection
    // ------------------------------------------------------------------
    // The rate bits change only on a load followed by the update delay, so two-flop
    // level crossing suffices; a short skew between the two bits is harmless.
    mrb_sync #(.WIDTH(3)) u_rate_sync (
        .clk (sys_clk),
        .d   ({l_reg.second_act[mrb_pkg::FORCED_RATE_BIT],
               l_reg.second_act[mrb_pkg::AUTO_RATE_BIT],
               case_temp_hot}),
        .q   (rate_sync)
    );

    mrb_pkg::mrb_sys_st_t s_reg;
    mrb_pkg::mrb_sys_st_t s_next;
    logic                 forced_s;
    logic                 auto_s;
    logic                 hot_s;

    assign forced_s = rate_sync[2];
    assign auto_s   = rate_sync[1];
    assign hot_s    = rate_sync[0];

    always_comb begin
        s_next = s_reg;
        // The sensor may trip a little below the nominal limit, which only errs toward safety.
        s_next.sr_double = forced_s || (auto_s && hot_s); // R6 R7 R8 R9
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_reg.sr_double <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign self_refresh_double = s_reg.sr_double;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    load_capture_a: assert property (@(posedge mem_clk) disable iff (!link_rst_b) // R26
        (op == mrb_pkg::OP_LOAD && cmd.ba == mrb_pkg::SEL_SECOND_EXT)
        |=> (l_reg.second_pend == $past({cmd.ba, cmd.addr})) && mode_update_busy)
        else $error("second register load not captured");

    load_hold_a: assert property (@(posedge mem_clk) disable iff (!link_rst_b) // R1
        !(op == mrb_pkg::OP_LOAD && cmd.ba == mrb_pkg::SEL_SECOND_EXT) |=> $stable(l_reg.second_pend))
        else $error("second register changed without a load");

    update_delay_a: assert property (@(posedge mem_clk) disable iff (!link_rst_b) // R26
        $changed(l_reg.third_act) |-> $past(l_reg.upd_cnt) == 8'h01)
        else $error("third register applied before update delay");

    write_latency_a: assert property (@(posedge mem_clk) disable iff (!link_rst_b) // R5
        (op == mrb_pkg::OP_WRITE && !pat_on && twl == 5'h05 && l_reg.wl_cnt == 5'h00)
        ##1 (op != mrb_pkg::OP_WRITE) [*4] |=> write_data_latch)
        else $error("write data not latched at total latency");

    term_write_only_a: assert property (@(posedge mem_clk) disable iff (!link_rst_b) // R15
        term_select == mrb_pkg::TERM_WRITE |-> write_burst_active && wr_dyn_en)
        else $error("write termination outside a write burst");

    term_leveling_a: assert property (@(posedge mem_clk) disable iff (!link_rst_b) // R16
        $past(write_leveling) |-> term_select != mrb_pkg::TERM_WRITE)
        else $error("write termination during write leveling");

    term_dynamic_a: assert property (@(posedge mem_clk) disable iff (!link_rst_b) // R13
        (write_data_latch && wr_dyn_en && !$past(write_leveling)) |-> term_select == mrb_pkg::TERM_WRITE)
        else $error("write termination missing at burst start");

    term_nominal_a: assert property (@(posedge mem_clk) disable iff (!link_rst_b) // R14
        term_select == mrb_pkg::TERM_NOM |-> $past(nominal_termination) != 3'h0)
        else $error("nominal termination while disabled");

    pattern_read_a: assert property (@(posedge mem_clk) disable iff (!link_rst_b) // R24
        (op == mrb_pkg::OP_READ && pat_on && l_reg.third_act[1:0] == mrb_pkg::PAT_SEL_CAL && !mode_update_busy)
        |=> pattern_valid && pattern_data == 8'hAA && !read_from_array)
        else $error("calibration pattern not returned");

    array_read_a: assert property (@(posedge mem_clk) disable iff (!link_rst_b) // R21
        (op == mrb_pkg::OP_READ && !pat_on && !mode_update_busy) |=> read_from_array && !pattern_valid)
        else $error("read not served by array");

    forced_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R9
        $past(forced_s) |-> self_refresh_double)
        else $error("forced double rate not applied");

    single_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R8
        ($past(!forced_s && !auto_s)) |-> !self_refresh_double)
        else $error("double rate with both rate bits clear");

    auto_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
        $past(auto_s && hot_s) |-> self_refresh_double)
        else $error("automatic rate did not double when hot");

endmodule : mrb_mode_regs

// [hdl/mrb_pkg.sv]
package mrb_pkg;

    // ------------------------------------------------------------------
    // Command decode and register selection
    // ------------------------------------------------------------------
    localparam logic [2:0]  SEL_SECOND_EXT   = 3'h2;
    localparam logic [2:0]  SEL_THIRD_EXT    = 3'h3;
    localparam int          MODE_REG_W       = 19;
    localparam logic [18:0] MODE_REG_RESET   = 19'h00000;

    // ------------------------------------------------------------------
    // Field positions of the second extended config register
    // ------------------------------------------------------------------
    localparam int          CWL_LSB          = 3;
    localparam int          CWL_MSB          = 5;
    localparam int          AUTO_RATE_BIT    = 6;
    localparam int          FORCED_RATE_BIT  = 7;
    localparam int          WR_TERM_LSB      = 9;
    localparam int          WR_TERM_MSB      = 10;

    // ------------------------------------------------------------------
    // Field positions of the third extended config register
    // ------------------------------------------------------------------
    localparam int          PAT_EN_BIT       = 2;
    localparam int          PAT_SEL_LSB      = 0;
    localparam int          PAT_SEL_MSB      = 1;
    localparam logic [1:0]  PAT_SEL_CAL      = 2'h0;
    localparam logic [7:0]  CAL_PATTERN      = 8'hAA;

    // ------------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------------
    localparam logic [4:0]  CWL_BASE         = 5'h05;
    localparam logic [2:0]  BURST_CLOCKS     = 3'h4;
    localparam int          MODE_UPDATE_DEF  = 12;
    localparam logic [7:0]  UPD_CNT_RESET    = 8'h00;
    localparam logic [4:0]  WL_CNT_RESET     = 5'h00;
    localparam logic [2:0]  BURST_CNT_RESET  = 3'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TERM_OFF   = 2'b00,
        TERM_NOM   = 2'b01,
        TERM_WRITE = 2'b10
    } mrb_term_t;

    typedef enum logic [1:0] {
        OP_NONE  = 2'b00,
        OP_LOAD  = 2'b01,
        OP_WRITE = 2'b10,
        OP_READ  = 2'b11
    } mrb_op_t;

    typedef struct packed {
        logic        cs_b;
        logic        ras_b;
        logic        cas_b;
        logic        we_b;
        logic [2:0]  ba;
        logic [15:0] addr;
    } mrb_cmd_t;

    typedef struct packed {
        logic [18:0] second_pend;
        logic [18:0] third_pend;
        logic [18:0] second_act;
        logic [18:0] third_act;
        logic [7:0]  upd_cnt;
        logic [4:0]  wl_cnt;
        logic [2:0]  burst_cnt;
        logic        wr_latch;
        logic        rd_array;
        logic        pat_valid;
        logic [7:0]  pat_data;
        mrb_term_t   term;
    } mrb_link_st_t;

    typedef struct packed {
        logic        sr_double;
    } mrb_sys_st_t;

endpackage : mrb_pkg

// [hdl/mrb_sync.sv]
`timescale 1ns/1ps

module mrb_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } mrb_sync_st_t;

    mrb_sync_st_t s_reg;
    mrb_sync_st_t s_next;

    // The first stage feeds only the second stage, never any logic.
    always_comb begin
        s_next.meta = d;
        s_next.q    = s_reg.meta;
    end

    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    assign q = s_reg.q;

endmodule : mrb_sync

// [tb/mrb_ctrl_model.sv]
`timescale 1ns/1ps

module mrb_ctrl_model #(
    parameter int UPD = 2
) (
    input  wire logic         mem_clk,
    output mrb_pkg::mrb_cmd_t cmd
);
    // ------------------------------------------------------------------
    // Command issue
    // ------------------------------------------------------------------
    initial begin
        cmd = {4'hF, 3'h0, 16'h0000};
    end

    // A released bus is deselected and shows the inverse of its last bank and address,
    // so a stale address can never pass for a fresh command.
    task automatic issue(input logic [3:0] s, input logic [2:0] ba, input logic [15:0] a);
        @(negedge mem_clk);
        cmd <= {s, ba, a};
        @(negedge mem_clk);
        cmd <= {4'hF, ~cmd.ba, ~cmd.addr};
    endtask : issue

    // No row is ever opened, so every bank is idle and precharged here.
    task automatic load(input logic [2:0] ba, input logic [15:0] a);
        logic [15:0] m;
        m = (ba == 3'h2) ? 16'h06F8 : 16'h0007;
        issue(4'h0, ba, a & m);
        repeat (UPD + 2) @(negedge mem_clk);
    endtask : load
endmodule : mrb_ctrl_model

// [tb/sdram_mode_regs_two_three_tb.sv]
`timescale 1ns/1ps

module sdram_mode_regs_two_three_tb;
    localparam int UPD   = 2;
    localparam int LIMIT = 40000;
    logic              sys_clk = 1'b0;
    logic              mem_clk = 1'b0;
    logic              rst_b;
    mrb_pkg::mrb_cmd_t cmd;
    logic [3:0]        al;
    logic [2:0]        nom;
    logic              tc;
    logic              wlev;
    logic              hot;
    logic              wdl;
    logic              wba;
    mrb_pkg::mrb_term_t term;
    logic [1:0]        wtv;
    logic              rfa;
    logic              pv;
    logic [7:0]        pd;
    logic              busy;
    logic              srd;
    int                error_cnt = 0;
    int                checks_done = 0;
    int                cyc = 0;

    always #2 sys_clk = ~sys_clk;
    always #62.5 mem_clk = ~mem_clk;

    mrb_ctrl_model #(.UPD(UPD)) u_ctrl (.mem_clk(mem_clk), .cmd(cmd));

    mrb_mode_regs #(.MODE_UPDATE_CYCLES(UPD), .AL_W(4)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .mem_clk(mem_clk), .cmd(cmd),
        .posted_latency_offset(al), .nominal_termination(nom), .termination_control(tc),
        .write_leveling(wlev), .case_temp_hot(hot), .write_data_latch(wdl),
        .write_burst_active(wba), .term_select(term), .write_termination_value(wtv),
        .read_from_array(rfa), .pattern_valid(pv), .pattern_data(pd),
        .mode_update_busy(busy), .self_refresh_double(srd)
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [15:0] mr2(input logic [1:0] wt, input logic f, input logic au, input logic [2:0] cw);
        return {5'h00, wt, 1'b0, f, au, cw, 3'h0};
    endfunction : mr2

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_load();
        u_ctrl.load(3'h2, mr2(2'h2, 1'b0, 1'b0, 3'h0));
        u_ctrl.issue(4'h0, 3'h2, mr2(2'h1, 1'b0, 1'b0, 3'h0));
        chk({busy, wtv}, {1'b1, 2'h2});
        @(negedge mem_clk);
        chk(busy, 1'b1);
        @(negedge mem_clk);
        chk({busy, wtv}, {1'b0, 2'h1});
        u_ctrl.load(3'h1, mr2(2'h3, 1'b0, 1'b0, 3'h0));
        chk(wtv, 2'h1);
        $display("load test done");
    endtask : t_load

    task automatic t_write(input logic [2:0] cw, input logic [3:0] a, input logic [1:0] wt,
                           input logic [2:0] nm, input logic lv);
        int n;
        mrb_pkg::mrb_term_t rest;
        @(negedge mem_clk);
        al = a;
        nom = nm;
        wlev = lv;
        tc = 1'b1;
        rest = (nm != 3'h0) ? mrb_pkg::TERM_NOM : mrb_pkg::TERM_OFF;
        u_ctrl.load(3'h2, mr2(wt, 1'b0, 1'b0, cw));
        chk(term, rest);
        u_ctrl.issue(4'h4, 3'h0, 16'h0000);
        n = 1;
        while (wdl !== 1'b1 && n < 40) begin
            @(negedge mem_clk);
            n++;
        end
        chk(n, 5 + cw + a);
        chk(wba, 1'b1);
        chk(term, (wt != 2'h0 && !lv) ? mrb_pkg::TERM_WRITE : rest);
        repeat (4) @(negedge mem_clk);
        chk({wba, wtv}, {1'b0, wt});
        chk(term, rest);
        $display("write test done");
    endtask : t_write

    task automatic t_read(input logic [2:0] m3, input logic pe, input logic [7:0] pdx);
        tc = 1'b0;
        u_ctrl.load(3'h3, {13'h0000, m3});
        u_ctrl.issue(4'h5, 3'h0, 16'h0000);
        chk({rfa, pv, pd}, {~pe, pe, pdx});
        chk(term, mrb_pkg::TERM_OFF);
        $display("read test done");
    endtask : t_read

    // A fixed wait, not a poll, so a wrong level that is already present cannot slip through.
    task automatic t_rate(input logic f, input logic au, input logic h, input logic e);
        hot = h;
        u_ctrl.load(3'h2, mr2(2'h0, f, au, 3'h0));
        repeat (8) @(negedge sys_clk);
        chk(srd, e);
        $display("rate test done");
    endtask : t_rate

    initial begin
        rst_b = 1'b0;
        al = 4'h0;
        nom = 3'h0;
        tc = 1'b0;
        wlev = 1'b0;
        hot = 1'b0;
        repeat (5) @(posedge mem_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge mem_clk);
        chk({wdl, wba, rfa, pv, busy, srd, wtv}, 8'h00);
        chk(term, mrb_pkg::TERM_OFF);
        t_load();
        t_write(3'h0, 4'h0, 2'h1, 3'h1, 1'b0);
        t_write(3'h7, 4'h3, 2'h2, 3'h0, 1'b0);
        t_write(3'h2, 4'h1, 2'h1, 3'h2, 1'b1);
        t_write(3'h1, 4'h0, 2'h0, 3'h1, 1'b0);
        t_read(3'h4, 1'b1, 8'hAA);
        t_read(3'h5, 1'b1, 8'h00);
        t_read(3'h3, 1'b0, 8'h00);
        t_read(3'h0, 1'b0, 8'h00);
        t_rate(1'b0, 1'b1, 1'b0, 1'b0);
        t_rate(1'b0, 1'b1, 1'b1, 1'b1);
        t_rate(1'b1, 1'b0, 1'b0, 1'b1);
        t_rate(1'b0, 1'b0, 1'b1, 1'b0);
        close_out();
    end
endmodule : sdram_mode_regs_two_three_tb
